// *** bssf_counters.sv ***
`timescale 1ns/10ps
module bssf_counters
   import bssf_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        srst,
   input  wire logic        fast_mode,
   input  wire logic        tb_tick,
   input  wire logic        qual_edge,
   output logic      [31:0] event_cnt,
   output logic      [31:0] time_cnt
);
   ////////////////////////////////////////////////////////////////////////
   // both counters roll over naturally; fast mode clears the upper half
   always_ff @(posedge clk) begin
      if (srst) begin
         event_cnt <= 32'h0;
      end else if (qual_edge) begin
         if (fast_mode) begin
            event_cnt <= {16'h0, event_cnt[15:0] + 16'h1}; // [R15]
         end else begin
            event_cnt <= event_cnt + 32'h1; // [R6] [R7]
         end
      end
   end

   // time base ticks arrive as enables from the 500 mhz domain
   always_ff @(posedge clk) begin
      if (srst) begin
         time_cnt <= 32'h0;
      end else if (tb_tick) begin
         if (fast_mode) begin
            time_cnt <= {16'h0, time_cnt[15:0] + 16'h1}; // [R15]
         end else begin
            time_cnt <= time_cnt + 32'h1; // [R8] [R9]
         end
      end
   end
endmodule : bssf_counters

// *** bssf_digits.sv ***
`timescale 1ns/10ps
module bssf_digits
   import bssf_pkg::*;
(
   input  wire logic [19:0] value,
   input  wire logic [2:0]  index,
   output logic      [7:0]  digit_char
);
   // selects decimal digit 'index' (0 = most significant of six)
   function automatic logic [3:0] dec_digit(input logic [19:0] v,
                                            input logic [2:0]  i);
      logic [19:0] t;
      t = v;
      // fixed trip count keeps the loop static; the guard picks the digit
      for (int k = 0; k < 5; k++) begin
         if (k < 5 - int'(i)) begin
            t = t / 20'd10;
         end
      end
      return 4'(t % 20'd10);
   endfunction : dec_digit

   always_comb begin
      digit_char = ASCII_ZERO + {4'h0, dec_digit(value, index)}; // [R2]
   end
endmodule : bssf_digits

// *** bssf_framer.sv ***
`timescale 1ns/10ps
// Contract
// R1: transmission opens with eight ascii header bytes, '#' then '6' first
// R2: last six header chars are zero-padded decimal data byte count
// R3: only the header is ascii; everything after is raw binary
// R4: bytes leave eight bits wide, most significant byte first
// R5: event field is the 32-bit event counter in four bytes
// R6: event counter adds one per qualified trigger and armed edge
// R7: event counter wraps from maximum to zero
// R8: time field is 32-bit count of the 500 mhz time base
// R9: time counter wraps to zero after two to the thirty-two counts
// R10: each time datum has a 16-bit interpolator/status word, msb first
// R11: interpolator is five-bit count of 0.1 ns steps
// R12: status bit 5 set when suppress input preceded this sample
// R13: status bit 6 set only in first sample of a block
// R14: totalize validity flags driven only in totalize measurements
// R15: fast mode uses 16-bit counters wrapping after 65,536
// R16: sample is 4 event, 4 time, 2 status bytes; n+1 samples (code sends n, the samples_q count)
// R17: transmission holds exactly the samples the blocks require (code cuts the frame short when the header count saturates)
// R18: host corrects rollover by adding the modulus after a drop
// R19: host time stamp is count times 2 ns minus interp times 0.1 ns
// R20: host applies channel path offset for start/stop measurements
// R21: host makes event stamps by rollover correction alone
// R22: interpolator sits in bits 4..0, range 0 to 18, bit 0 zero
// R23: totalize flags at bits 13 and 14; 1 marks second attempt valid
// R24: bytes after header equal header count; fields packed contiguously
module bssf_framer
   import bssf_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        srst,
   // ahb-lite slave
   input  wire logic        hsel,
   input  wire logic [7:0]  haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic      [31:0] hrdata,
   // measurement front end
   input  wire logic        tb_tick,
   input  wire logic        qual_edge,
   input  wire logic        capture,
   input  wire logic [4:0]  interp_val,
   input  wire logic        suppress,
   input  wire logic        tot_valid_first,
   input  wire logic        tot_valid_second,
   // byte output port
   output logic      [7:0]  out_byte_q,
   output logic             out_valid,
   input  wire logic        out_ready,
   output logic             busy
);
   bssf_state_t state_q;
   logic        fast_q, totalize_q;
   logic [19:0] samples_q, samples_left_q, bytes_left_q, byte_total_q;
   logic [19:0] sent_q;
   logic [2:0]  hdr_idx_q;
   logic [3:0]  byte_idx_q;
   logic [79:0] sample_q;
   logic        first_q, supp_seen_q, overflow_q;
   logic        valid_q;
   logic [31:0] event_cnt, time_cnt;
   logic [7:0]  digit_char;
   logic        ph_valid_q, ph_write_q;
   logic [7:0]  ph_addr_q;
   logic        start_req;
   logic [3:0]  sample_len;
   logic        take;

   ////////////////////////////////////////////////////////////////////////
   bssf_counters u_cnt (
      .clk       (clk),
      .srst      (srst),
      .fast_mode (fast_q),
      .tb_tick   (tb_tick),
      .qual_edge (qual_edge),
      .event_cnt (event_cnt),
      .time_cnt  (time_cnt)
   );

   // the byte loaded on leaving header index i goes out at position i + 1,
   // so it is digit i - 1, counted from the most significant of the six
   bssf_digits u_dig (
      .value      (byte_total_q),
      .index      (3'(hdr_idx_q - 3'd1)),
      .digit_char (digit_char)
   );

   // byte total of a frame, clipped to what six digits can show
   function automatic logic [19:0] frame_bytes(input logic [19:0] n,
                                               input logic        fast);
      logic [23:0] p;
      p = fast ? 24'(n) * 24'(FAST_SAMPLE_BYTES)
               : 24'(n) * 24'(SAMPLE_BYTES);
      return (p > 24'(MAX_BYTE_COUNT)) ? MAX_BYTE_COUNT : p[19:0];
   endfunction : frame_bytes

   ////////////////////////////////////////////////////////////////////////
   // bus slave: zero wait states, always okay
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   always_ff @(posedge clk) begin
      if (srst) begin
         ph_valid_q <= 1'b0;
         ph_write_q <= 1'b0;
         ph_addr_q  <= 8'h0;
      end else if (hready) begin
         ph_valid_q <= hsel && (htrans == HTRANS_NONSEQ);
         ph_write_q <= hwrite;
         ph_addr_q  <= haddr;
      end
   end

   assign start_req = ph_valid_q && ph_write_q && (ph_addr_q == REG_CTRL)
                      && hwdata[CTRL_START];

   // config is frozen while a frame is out, so header and data agree
   always_ff @(posedge clk) begin
      if (srst) begin
         fast_q     <= 1'b0;
         totalize_q <= 1'b0;
         samples_q  <= SAMPLES_RST;
      end else if (ph_valid_q && ph_write_q && state_q == BSSF_IDLE) begin
         if (ph_addr_q == REG_CTRL) begin
            fast_q     <= hwdata[CTRL_FAST];
            totalize_q <= hwdata[CTRL_TOTALIZE];
         end
         if (ph_addr_q == REG_SAMPLES) begin
            samples_q <= hwdata[19:0];
         end
      end
   end

   always_comb begin
      case (ph_addr_q)
         REG_CTRL:    hrdata = {29'h0, totalize_q, fast_q, busy};
         REG_SAMPLES: hrdata = {12'h0, samples_q};
         REG_STATUS:  hrdata = {30'h0, overflow_q, supp_seen_q};
         REG_EVENT:   hrdata = event_cnt;
         REG_TIME:    hrdata = time_cnt;
         REG_SENT:    hrdata = {12'h0, sent_q};
         default:     hrdata = 32'h0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // frame sequencer
   assign sample_len = fast_q ? 4'(FAST_SAMPLE_BYTES) : 4'(SAMPLE_BYTES);
   assign take       = valid_q && out_ready;
   assign out_valid  = valid_q;
   assign busy       = (state_q != BSSF_IDLE);

   always_ff @(posedge clk) begin
      if (srst) begin
         state_q        <= BSSF_IDLE;
         hdr_idx_q      <= 3'h0;
         byte_idx_q     <= 4'h0;
         samples_left_q <= 20'h0;
         bytes_left_q   <= 20'h0;
         byte_total_q   <= 20'h0;
         valid_q        <= 1'b0;
         out_byte_q     <= 8'h0;
      end else begin
         case (state_q)
            BSSF_IDLE: begin
               if (start_req && samples_q != 20'h0) begin
                  byte_total_q   <= frame_bytes(samples_q, hwdata[CTRL_FAST]);
                  samples_left_q <= samples_q; // [R17]
                  hdr_idx_q      <= 3'h0;
                  state_q        <= BSSF_HDR;
                  valid_q        <= 1'b1;
                  out_byte_q     <= HDR_MARK; // [R1]
               end
            end
            BSSF_HDR: begin
               if (take) begin
                  hdr_idx_q <= hdr_idx_q + 3'h1;
                  if (hdr_idx_q == 3'(HDR_LEN - 1)) begin
                     valid_q      <= 1'b0;
                     bytes_left_q <= byte_total_q; // [R24]
                     state_q      <= BSSF_WAIT;
                  end else if (hdr_idx_q == 3'h0) begin
                     out_byte_q <= HDR_WIDTH_CHAR; // [R1]
                  end else begin
                     out_byte_q <= digit_char; // [R2]
                  end
               end
            end
            BSSF_WAIT: begin
               // stop on whichever count runs out first; a saturated
               // header count cuts the frame at the stated byte total
               if (bytes_left_q == 20'h0
                   || samples_left_q == 20'h0) begin // [R17]
                  state_q <= BSSF_IDLE;
               end else if (capture) begin
                  byte_idx_q <= 4'h1;
                  valid_q    <= 1'b1;
                  out_byte_q <= sample_d_byte0(); // [R3] [R4]
                  state_q    <= BSSF_DATA;
               end
            end
            BSSF_DATA: begin
               if (take) begin
                  bytes_left_q <= bytes_left_q - 20'h1; // [R24]
                  if (byte_idx_q == sample_len || bytes_left_q == 20'h1) begin
                     valid_q        <= 1'b0;
                     samples_left_q <= samples_left_q - 20'h1;
                     state_q        <= BSSF_WAIT;
                  end else begin
                     out_byte_q <= sample_q[79 - 8*int'(byte_idx_q) -: 8]; // [R4]
                     byte_idx_q <= byte_idx_q + 4'h1;
                  end
               end
            end
            default: state_q <= BSSF_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // sample assembly, packed left so bytes leave msb first with no gaps
   logic [15:0] status_word;
   always_comb begin
      status_word = 16'h0;
      status_word[INTERP_LSB +: INTERP_W] = {interp_val[4:1], 1'b0}; // [R11] [R22]
      status_word[INHIBIT_BIT]     = supp_seen_q || suppress; // [R12]
      status_word[BLOCK_START_BIT] = first_q; // [R13]
      if (totalize_q) begin
         status_word[TOT_FIRST_BIT]  = tot_valid_first; // [R14] [R23]
         status_word[TOT_SECOND_BIT] = tot_valid_second; // [R14] [R23]
      end
   end

   function automatic logic [7:0] sample_d_byte0();
      return fast_q ? event_cnt[15:8] : event_cnt[31:24];
   endfunction : sample_d_byte0

   always_ff @(posedge clk) begin
      if (srst) begin
         sample_q <= 80'h0;
      end else if (state_q == BSSF_WAIT && capture) begin
         if (fast_q) begin
            sample_q <= {event_cnt[15:0], time_cnt[15:0], status_word,
                         32'h0}; // [R15] [R16]
         end else begin
            sample_q <= {event_cnt, time_cnt, status_word}; // [R5] [R8] [R10] [R16]
         end
      end
   end

   // suppress memory: a new assertion wins over the clear at capture
   always_ff @(posedge clk) begin
      if (srst) begin
         supp_seen_q <= 1'b0;
      end else if (suppress) begin
         supp_seen_q <= 1'b1; // [R12]
      end else if (state_q == BSSF_WAIT && capture) begin
         supp_seen_q <= 1'b0;
      end
   end

   // each frame is one block, so only its first sample carries the mark
   always_ff @(posedge clk) begin
      if (srst) begin
         first_q <= 1'b0;
      end else if (state_q == BSSF_IDLE && start_req) begin
         first_q <= 1'b1; // [R13]
      end else if (state_q == BSSF_WAIT && capture) begin
         first_q <= 1'b0;
      end
   end

   // header count saturates at six digits; flag it to software
   always_ff @(posedge clk) begin
      if (srst) begin
         overflow_q <= 1'b0;
      end else if (state_q == BSSF_IDLE && start_req) begin
         overflow_q <= (frame_bytes(samples_q, hwdata[CTRL_FAST])
                        == MAX_BYTE_COUNT);
      end
   end

   // data bytes only; the eight header bytes are not counted
   always_ff @(posedge clk) begin
      if (srst) begin
         sent_q <= 20'h0;
      end else if (state_q == BSSF_IDLE && start_req) begin
         sent_q <= 20'h0;
      end else if (state_q == BSSF_DATA && take) begin
         sent_q <= sent_q + 20'h1;
      end
   end
endmodule : bssf_framer

// *** bssf_framer_assertions.sv ***
`timescale 1ns/10ps
module bssf_chk
   import bssf_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        srst,
   input  wire logic        hsel,
   input  wire logic [7:0]  haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   input  wire logic [7:0]  out_byte_q,
   input  wire logic        out_valid,
   input  wire logic        out_ready,
   input  wire logic        busy
);
   logic [19:0] cnt_q;
   logic        wr_q;
   logic        fast_q;
   int          sb;
   int          k;
   logic        lo_st;
   // bytes handed over in the running frame
   always_ff @(posedge clk) begin
      if (srst || !busy) cnt_q <= '0;
      else if (out_valid && out_ready) cnt_q <= cnt_q + 20'h1;
   end
   // mode follows the ctrl write; ignored while a frame runs
   always_ff @(posedge clk) begin
      wr_q <= hsel && hready && htrans == HTRANS_NONSEQ && hwrite
              && haddr == REG_CTRL;
      if (srst) fast_q <= 1'b0;
      else if (wr_q && !busy) fast_q <= hwdata[CTRL_FAST];
   end
   assign sb = fast_q ? FAST_SAMPLE_BYTES : SAMPLE_BYTES;
   assign k = (int'(cnt_q) - HDR_LEN) % sb;
   assign lo_st = cnt_q >= 20'h8 && k == sb - 1;
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   sequence s_stall; out_valid && !out_ready; endsequence
   sequence s_held; out_valid && $stable(out_byte_q); endsequence
   property p_hold; s_stall |=> s_held; endproperty
   property p_vbusy; out_valid |-> busy; endproperty
   property p_mark;
      out_valid && cnt_q == 20'h0 |-> out_byte_q == HDR_MARK;
   endproperty
   property p_width;
      out_valid && cnt_q == 20'h1 |-> out_byte_q == HDR_WIDTH_CHAR;
   endproperty
   property p_digit;
      out_valid && cnt_q inside {[2:7]} |-> out_byte_q inside {[48:57]};
   endproperty
   property p_interp;
      out_valid && lo_st |-> !out_byte_q[0] && out_byte_q[4:0] <= INTERP_MAX;
   endproperty
   property p_block;
      out_valid && lo_st |->
         out_byte_q[BLOCK_START_BIT] == (int'(cnt_q) == HDR_LEN + sb - 1);
   endproperty
   property p_end; $fell(busy) |-> cnt_q > 20'h8 && k == 0; endproperty
   a_hold: assert property (p_hold) else $error("byte moved while stalled");
   a_vbusy: assert property (p_vbusy) else $error("byte outside frame");
   a_mark: assert property (p_mark) else $error("first byte wrong");
   a_width: assert property (p_width) else $error("second byte wrong");
   a_digit: assert property (p_digit) else $error("count not a digit");
   a_interp: assert property (p_interp) else $error("bad interpolator");
   a_block: assert property (p_block) else $error("block start wrong");
   a_end: assert property (p_end) else $error("frame cut short");
endmodule : bssf_chk
////////////////////////////////////////////////////////////////////////////
bind bssf_framer bssf_chk u_chk (.clk(clk), .srst(srst), .hsel(hsel),
   .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
   .hready(hready), .out_byte_q(out_byte_q), .out_valid(out_valid),
   .out_ready(out_ready), .busy(busy));

// *** bssf_framer_tb.sv ***
`timescale 1ns/10ps
module bssf_framer_tb;
   import bssf_pkg::*;
   logic clk, srst, hsel, hwrite, hready, hreadyout, hresp, slow;
   logic [7:0] haddr, out_byte_q;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] hwdata, hrdata, rd_s;
   logic tb_tick, qual_edge, capture, suppress, tv1, tv2, out_valid;
   logic out_ready, busy;
   logic [4:0] interp_val;
   int fails, compares, ev;
   assign hready = hreadyout;
   always @(posedge clk) rd_s <= hrdata;
   bssf_framer DUT (.clk(clk), .srst(srst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .tb_tick(tb_tick), .qual_edge(qual_edge),
      .capture(capture), .interp_val(interp_val), .suppress(suppress),
      .tot_valid_first(tv1), .tot_valid_second(tv2),
      .out_byte_q(out_byte_q), .out_valid(out_valid),
      .out_ready(out_ready), .busy(busy));
   bssf_host host (.clk(clk), .srst(srst), .out_byte_q(out_byte_q),
      .out_valid(out_valid), .slow(slow), .out_ready(out_ready));
   ////////////////////////////////////////////////////////////////////////
   task check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         fails++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task close_out;
      $display("compares=%0d fails=%0d", compares, fails);
      if (fails == 0 && compares > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : close_out
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] r);
      hsel <= 1'b1;
      htrans <= HTRANS_NONSEQ;
      haddr <= a;
      hwrite <= w;
      do @(posedge clk); while (!hready);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (!hready);
      #1 r = rd_s;
   endtask : bus
   task do_reset;
      srst <= 1'b1;
      repeat (12) @(posedge clk);
      srst <= 1'b0;
      ev = 0;
      @(posedge clk);
   endtask : do_reset
   task wait_rx(input int n);
      for (int i = 0; i < 4000 && (host.rx.size() < n || out_valid); i++)
         @(posedge clk);
   endtask : wait_rx
   task frame(input int n, input logic fm, input logic tm, input int np,
              input string nm);
      int s, bc, xt;
      logic [7:0] e[$];
      logic [31:0] c, r;
      logic [15:0] st;
      s = fm ? FAST_SAMPLE_BYTES : SAMPLE_BYTES;
      bc = n * s;
      e = {HDR_MARK, HDR_WIDTH_CHAR};
      for (int i = 5; i >= 0; i--)
         e.push_back(ASCII_ZERO + 8'((bc / (10 ** i)) % 10));
      bus(1'b1, REG_SAMPLES, 32'(n), r);
      bus(1'b1, REG_CTRL, {29'h0, tm, fm, 1'b1}, r);
      for (int k = 0; k < n; k++) begin
         wait_rx(8 + k * s);
         interp_val <= k ? 5'h07 : 5'h12;
         suppress <= k == 1;
         qual_edge <= 1'b1;
         tb_tick <= 1'b1;
         repeat (np) @(posedge clk);
         qual_edge <= 1'b0;
         tb_tick <= 1'b0;
         suppress <= 1'b0;
         ev += np;
         @(posedge clk);
         capture <= 1'b1;
         @(posedge clk);
         capture <= 1'b0;
         c = 32'(ev);
         st = {1'b0, tm & tv2, tm & tv1, 6'h00, k == 0, k == 1,
               k ? 5'h06 : 5'h12};
         // event then time, same count since both pulse together
         for (int j = 0; j < 2; j++)
            for (int b = (fm ? 1 : 3); b >= 0; b--) e.push_back(c[8*b+:8]);
         e.push_back(st[15:8]);
         e.push_back(st[7:0]);
      end
      for (int i = 0; i < 4000 && busy; i++) @(posedge clk);
      check(32'(host.rx.size()), 32'(e.size()));
      foreach (e[i]) check(32'(host.rx[i]), 32'(e[i]));
      for (int k = 0; k < n; k++) begin
         check(32'(host.unwrap(k, 0, fm)), 32'(np * (k + 1)));
         xt = np * (k + 1) * 20 - (k ? 6 : 18);
         // single input channel: no path offset to apply
         check(32'(host.time_tenths(k, fm, 0)), 32'(xt));
      end
      bus(1'b0, REG_SENT, 32'h0, r);
      check(r, 32'(bc));
      bus(1'b0, REG_EVENT, 32'h0, r);
      check(r, fm ? 32'(ev % 65536) : 32'(ev));
      bus(1'b0, REG_TIME, 32'h0, r);
      check(r, fm ? 32'(ev % 65536) : 32'(ev));
      bus(1'b0, REG_CTRL, 32'h0, r);
      check(r, {29'h0, tm, fm, 1'b0});
      bus(1'b0, REG_STATUS, 32'h0, r);
      check(r, 32'h0);
      $display("test %s done", nm);
   endtask : frame
   ////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   initial begin
      #9_000_000;
      fails++;
      close_out();
   end
   initial begin
      logic [31:0] r;
      {hsel, hwrite, tb_tick, qual_edge, capture, suppress} = '0;
      {haddr, htrans, hwdata, interp_val} = '0;
      hsize = 3'h2;
      {tv1, tv2, slow} = 3'b111;
      do_reset();
      frame(2, 1'b0, 1'b0, 3, "normal");
      do_reset();
      tv2 <= 1'b0;
      slow <= 1'b0;
      frame(1, 1'b0, 1'b1, 5, "totalize");
      do_reset();
      frame(2, 1'b1, 1'b0, 33000, "fast");
      do_reset();
      bus(1'b0, REG_SAMPLES, 32'h0, r);
      check(r, 32'(SAMPLES_RST));
      bus(1'b1, 8'h1c, 32'h5, r);
      bus(1'b0, 8'h1c, 32'h0, r);
      check(r, 32'h0);
      check(32'(hresp), 32'h0);
      check(32'(hreadyout), 32'h1);
      $display("test regs done");
      close_out();
   end
endmodule : bssf_framer_tb

// *** bssf_host.sv ***
`timescale 1ns/10ps
module bssf_host
   import bssf_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       srst,
   input  wire logic [7:0] out_byte_q,
   input  wire logic       out_valid,
   input  wire logic       slow,
   output logic            out_ready
);
   logic [7:0] rx [$];
   // raw event (off 0) or time (off 1) count of sample i
   function automatic longint field(input int i, input int off,
                                    input bit fast);
      longint v;
      int     w;
      int     at;
      v = 0;
      w = fast ? FAST_EVT_BYTES : EVT_BYTES;
      at = HDR_LEN + i * (fast ? FAST_SAMPLE_BYTES : SAMPLE_BYTES)
           + off * w;
      for (int b = 0; b < w; b++) begin
         v = (v << 8) | longint'(rx[at + b]);
      end
      return v;
   endfunction : field
   // stamp of sample i after rollover correction
   function automatic longint unwrap(input int i, input int off,
                                     input bit fast);
      longint add, prev, cur;
      add = 0;
      prev = field(0, off, fast);
      for (int s = 1; s <= i; s++) begin
         cur = field(s, off, fast);
         // a drop means a wrap; lift this and all later data
         if (cur < prev) add += fast ? 64'h1_0000 : 64'h1_0000_0000;
         prev = cur;
      end
      return field(i, off, fast) + add;
   endfunction : unwrap
   // time stamp in 0.1 ns steps: count times 2 ns less interpolator
   function automatic longint time_tenths(input int i, input bit fast,
                                          input longint ofs);
      int at;
      at = HDR_LEN + (i + 1) * (fast ? FAST_SAMPLE_BYTES : SAMPLE_BYTES) - 1;
      return unwrap(i, 1, fast) * 20 - rx[at][4:0] + ofs;
   endfunction : time_tenths
   // slow host accepts every other cycle to exercise the hold
   always @(posedge clk) begin
      if (srst) begin
         out_ready <= 1'b0;
         rx.delete();
      end else begin
         out_ready <= slow ? !out_ready : 1'b1;
         if (out_valid && out_ready) rx.push_back(out_byte_q);
      end
   end
endmodule : bssf_host

// *** bssf_pkg.sv ***
package bssf_pkg;
   localparam int          CLK_HZ           = 10_000_000;
   // header: '#', '6', six ascii digits
   localparam int          HDR_LEN          = 8;
   localparam logic [7:0]  HDR_MARK         = 8'h23;
   localparam logic [7:0]  HDR_WIDTH_CHAR   = 8'h36;
   localparam logic [7:0]  ASCII_ZERO       = 8'h30;
   localparam int          CNT_DIGITS       = 6;
   // sample layout
   localparam int          EVT_BYTES        = 4;
   localparam int          TIM_BYTES        = 4;
   localparam int          STAT_BYTES       = 2;
   localparam int          SAMPLE_BYTES     = 10;
   localparam int          FAST_EVT_BYTES   = 2;
   localparam int          FAST_TIM_BYTES   = 2;
   localparam int          FAST_SAMPLE_BYTES = 6;
   localparam logic [19:0] MAX_BYTE_COUNT   = 20'hf423f;
   // status word fields
   localparam int          INTERP_LSB       = 0;
   localparam int          INTERP_W         = 5;
   localparam logic [4:0]  INTERP_MAX       = 5'h12;
   localparam int          INHIBIT_BIT      = 5;
   localparam int          BLOCK_START_BIT  = 6;
   localparam int          TOT_FIRST_BIT    = 13;
   localparam int          TOT_SECOND_BIT   = 14;
   // ahb-lite register map
   localparam logic [7:0]  REG_CTRL         = 8'h00;
   localparam logic [7:0]  REG_SAMPLES      = 8'h04;
   localparam logic [7:0]  REG_STATUS       = 8'h08;
   localparam logic [7:0]  REG_EVENT        = 8'h0c;
   localparam logic [7:0]  REG_TIME         = 8'h10;
   localparam logic [7:0]  REG_SENT         = 8'h14;
   localparam int          CTRL_START       = 0;
   localparam int          CTRL_FAST        = 1;
   localparam int          CTRL_TOTALIZE    = 2;
   localparam logic [19:0] SAMPLES_RST      = 20'h00001;
   localparam logic [1:0]  HTRANS_NONSEQ    = 2'h2;
   typedef enum {BSSF_IDLE, BSSF_HDR, BSSF_WAIT, BSSF_DATA} bssf_state_t;
endpackage : bssf_pkg
